// ===== dv/nibble_checker.sv
`timescale 1ns/1ns
// ---
// port checks
// ---
module nibble_checker (
  // watched ports
  input wire core_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, frameStart,
  input wire overheadIndicator, nibbleFrameBoundary, payloadValid,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire [3:0] payloadNibble, payloadNibbleIn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  oh_low_a: assert property (!overheadIndicator)
    else $error("overhead high");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  unmapped_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0c |-> wb_dat_o == 32'h0)
    else $error("unmapped data");
  capture_a: assert property (payloadValid |-> payloadNibble == payloadNibbleIn)
    else $error("bad capture");
  valid_one_a: assert property (payloadValid |=> !payloadValid)
    else $error("valid long");
  start_one_a: assert property (frameStart |=> !frameStart)
    else $error("start long");
  bd_width_a: assert property ($rose(nibbleFrameBoundary) |=>
    nibbleFrameBoundary [*8] ##[1:40] !nibbleFrameBoundary) else $error("boundary width");
endmodule // nibble_checker
bind ds3_nibble_payload_input nibble_checker nibble_checker_i (.*);

// ===== dv/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb;
  // ---
  // bench
  // ---
  reg core_clk = 0, rstn = 0, clkEn = 1, parallelSelectPin = 1, holdRef = 0;
  reg wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, nP = 0, bP = 0;
  reg [1:0] div = 0;
  reg [3:0] wb_sel_i = 4'hf;
  reg [7:0] wb_adr_i = 0;
  reg [31:0] wb_dat_i = 0, q;
  wire receiveLineClock = div[1];
  wire localTransmitClock = div[1];
  wire nibbleInterfaceClock, nibbleFrameBoundary, overheadIndicator, payloadValid, frameStart;
  wire wb_ack_o, frameReferenceIn;
  wire [3:0] payloadNibbleIn, payloadNibble;
  wire [31:0] wb_dat_o;
  int failCount = 0, testsRun = 0, len = 0, nibs = 0, n = 0, s = 0, mon = 0;
  ds3_nibble_payload_input ds3_nibble_payload_input_i (.*);
  terminal_model terminal_model_i (.*);
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    {div, nP, bP} <= {div + 2'h1, nibbleInterfaceClock, nibbleFrameBoundary};
    len++;
    nibs += nibbleInterfaceClock && !nP;
    if (nibbleFrameBoundary && !bP) begin
      if (mon > 1) `CHK("nibbles", 1176, nibs)
      if (mon > 1) `CHK("cycles", 18872, len)
      mon += mon > 0;
      n++;
      len = 0;
      nibs = 0;
    end
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge core_clk);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (k == 20) begin failCount++; wrap_up(); end
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1;
    repeat (3) @(posedge core_clk);
    wb(0, 8'h00, 0); `CHK("opmode", 32'h2a, q)
    wb(1, 8'h10, 32'hff); wb(0, 8'h10, 0); `CHK("unmapped", 32'h0, q)
    wb(1, 8'h00, 32'h80); wb(0, 8'h00, 0); `CHK("loop mode", 32'h0, q)
    $display("regs done");
    mon = 1;
    n = 0;
    for (int k = 0; k < 45000 && n < 2; k++) @(posedge core_clk);
    `CHK("frames", 2, n)
    mon = 0;
    if (n < 2) wrap_up();
    $display("loop done");
    wb(0, 8'h04, 0); `CHK("loop status", 32'h5, q & 32'hd)
    wb(1, 8'h00, 32'h81); wb(0, 8'h00, 0); `CHK("slave mode", 32'h81, q)
    repeat (100) @(posedge core_clk);
    holdRef <= 1;
    for (int k = 0; k < 300; k++) begin @(posedge core_clk); s += frameStart === 1'b1; end
    holdRef <= 0;
    `CHK("starts", 1, s)
    wb(0, 8'h04, 0); `CHK("slave status", 32'h9, q & 32'h1d)
    $display("ref done");
    wrap_up();
  end
endmodule // tb

// ===== dv/terminal_model.sv
`timescale 1ns/1ns
// ---
// terminal equipment
// ---
module terminal_model (
  // clock, reset, fault command
  input wire core_clk, rstn, holdRef,
  // framer side
  input wire nibbleInterfaceClock, nibbleFrameBoundary,
  output reg [3:0] payloadNibbleIn,
  output wire frameReferenceIn
);
  reg nP, wasBd, pulse;
  assign frameReferenceIn = pulse | holdRef;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {nP, wasBd, pulse, payloadNibbleIn} <= 7'h0;
    end else begin
      nP <= nibbleInterfaceClock;
      if (nibbleInterfaceClock && !nP) begin
        payloadNibbleIn <= wasBd ? 4'h0 : payloadNibbleIn + 4'h1;
        pulse <= wasBd;
        wasBd <= nibbleFrameBoundary;
      end
    end
  end
endmodule // terminal_model

// ===== logic/ds3_nibble_payload_input.v
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "nibble_input_defines.vh"
// How it works
// R01: device sources the shared nibble clock
// R02: loop mode divides line clock by four
// R03: terminal launches nibbles on rising nibble clock
// R04: device captures nibble on its nibble clock
// R05: boundary pulse high during last nibble
// R06: terminal presents first nibble after boundary
// R07: overhead indicator held low in nibble mode
// R08: loop mode: select pin high, field 00
// R09: no local loopback in loop-timed mode
// R10: slave mode divides local clock by four
// R11: frame reference rising edge starts new frame
// R12: terminal pulses reference with first nibble
// R13: slave mode samples third edge after pulse
// R14: loop mode samples third edge after pulse
// R15: 1176 nibble pulses per frame
// R16: gaps of four, fourteen gaps of five
// R17: port carries payload nibbles only
// R18: overhead generated internally
// R19: slave mode: select pin high, field 01
// R20: frame reference taken only on rising edge
module ds3_nibble_payload_input (
  // clock, reset, enable
  input wire core_clk,
  input wire rstn,
  input wire clkEn,
  // reference clock ticks, sampled on core_clk
  input wire receiveLineClock,
  input wire localTransmitClock,
  // configuration pin
  input wire parallelSelectPin,
  // terminal side
  input wire [3:0] payloadNibbleIn,
  input wire frameReferenceIn,
  output reg nibbleInterfaceClock,
  output reg nibbleFrameBoundary,
  output reg overheadIndicator,
  // captured payload toward the framer core
  output reg [3:0] payloadNibble,
  output reg payloadValid,
  output reg frameStart,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rstMeta;
  reg rstSync;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] opMode;
  reg [15:0] frameCount;
  reg [3:0] lastNibble;
  reg refIgnored;
  wire [1:0] timingReferenceSelect = opMode[`TIMREF_MSB:`TIMREF_LSB];
  wire loopMode = parallelSelectPin && (timingReferenceSelect == `TIMREF_LOOP); // see R08
  wire slaveMode = parallelSelectPin && (timingReferenceSelect == `TIMREF_SLAVE); // see R19
  wire active = loopMode || slaveMode;
  wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0;
    case (wb_adr_i)
      `ADDR_OPMODE: next_rdata = {24'h0, opMode};
      `ADDR_STATUS: next_rdata = {27'h0, refIgnored, slaveMode, loopMode,
                                  nibbleFrameBoundary, active};
      `ADDR_NIBBLE: next_rdata = {28'h0, lastNibble};
      `ADDR_FRAMECNT: next_rdata = {16'h0, frameCount};
      default: next_rdata = 32'h0;
    endcase
  end

  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      opMode <= `OPMODE_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clkEn) begin
      wb_ack_o <= wbReq;
      if (wbReq) begin
        wb_dat_o <= next_rdata;
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `ADDR_OPMODE) begin
          opMode <= wb_dat_i[7:0];
          // loopback cannot be set while loop-timed
          if (parallelSelectPin && wb_dat_i[1:0] == `TIMREF_LOOP)
            opMode[`LOOPBACK_BIT] <= 1'b0; // see R09
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reference clock edge detect
  // ----------------------------------------------------------------
  wire refClk = loopMode ? receiveLineClock : localTransmitClock; // see R02 see R10
  reg refClkQ;
  reg refQ;
  wire refTick = refClk && !refClkQ;
  wire refRise = frameReferenceIn && !refQ; // see R20

  // ----------------------------------------------------------------
  // nibble clock generator and frame counter
  // ----------------------------------------------------------------
  reg [2:0] phase;
  reg [2:0] gap;
  reg [10:0] nibIndex;
  reg [6:0] longCnt;
  reg [2:0] sampleCnt;
  reg sampleArm;
  wire [2:0] next_gap = (longCnt == 7'd0) ? `NIB_GAP_LONG : `NIB_GAP; // see R16
  wire nibbleEdge = refTick && (phase == gap - 3'd1);

  always @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      refClkQ <= 1'b0;
      refQ <= 1'b0;
      phase <= 3'h0;
      gap <= `NIB_GAP;
      nibIndex <= 11'h0;
      longCnt <= 7'h0;
      sampleCnt <= 3'h0;
      sampleArm <= 1'b0;
      nibbleInterfaceClock <= 1'b0;
      nibbleFrameBoundary <= 1'b0;
      overheadIndicator <= 1'b0;
      payloadNibble <= 4'h0;
      payloadValid <= 1'b0;
      frameStart <= 1'b0;
      lastNibble <= 4'h0;
      frameCount <= 16'h0;
      refIgnored <= 1'b0;
    end else if (clkEn) begin
      refClkQ <= refClk;
      refQ <= frameReferenceIn;
      overheadIndicator <= 1'b0; // see R07 see R18
      payloadValid <= 1'b0;
      frameStart <= 1'b0;
      if (!active) begin
        phase <= 3'h0;
        nibIndex <= 11'h0;
        nibbleInterfaceClock <= 1'b0;
        nibbleFrameBoundary <= 1'b0;
        sampleArm <= 1'b0;
      end else begin
        if (slaveMode && refRise) begin
          // restart the frame on the terminal's reference
          phase <= 3'h0;
          gap <= `NIB_GAP;
          nibIndex <= 11'h0;
          longCnt <= 7'h0;
          frameStart <= 1'b1; // see R11
          frameCount <= frameCount + 16'h1;
          refIgnored <= 1'b0;
        end else begin
          // a stray reference edge must not cost a reference tick
          if (refRise)
            refIgnored <= 1'b1;
          if (refTick) begin
          // nibble clock high for two reference ticks of each gap; one pulse per payload nibble
          nibbleInterfaceClock <= (phase == gap - 3'd1) || (phase < 3'd1); // see R01
          if (nibbleEdge) begin
            phase <= 3'h0;
            gap <= next_gap;
            longCnt <= ({4'h0, longCnt} == `LONG_GAP_SPACING - 11'd1) ? 7'h0 : longCnt + 7'h1;
            sampleCnt <= 3'h0;
            sampleArm <= 1'b1;
            if (nibIndex == `NIB_LAST) begin // see R15
              nibIndex <= 11'h0;
              longCnt <= 7'h0;
              if (loopMode) begin
                frameStart <= 1'b1;
                frameCount <= frameCount + 16'h1;
              end
            end else begin
              nibIndex <= nibIndex + 11'h1;
            end
            nibbleFrameBoundary <= (nibIndex == `NIB_LAST - 11'd1); // see R05
          end else begin
            phase <= phase + 3'h1;
          end
          if (sampleArm) begin
            if (sampleCnt == `SAMPLE_EDGE - 3'd1) begin
              // payload only; no overhead slots on this port
              payloadNibble <= payloadNibbleIn; // see R04 see R13 see R14 see R17
              lastNibble <= payloadNibbleIn;
              payloadValid <= 1'b1;
              sampleArm <= 1'b0;
            end
            sampleCnt <= sampleCnt + 3'h1;
          end
          end
        end
      end
    end
  end

endmodule // ds3_nibble_payload_input

// ===== logic/nibble_input_defines.vh
`ifndef NIBBLE_INPUT_DEFINES_VH
`define NIBBLE_INPUT_DEFINES_VH
// register byte addresses
`define ADDR_OPMODE 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_NIBBLE 8'h08
`define ADDR_FRAMECNT 8'h0c
// operating mode fields
`define OPMODE_RESET 8'h2a
`define TIMREF_LSB 0
`define TIMREF_MSB 1
`define FRAMEFMT_BIT 2
`define LOOPBACK_BIT 7
// timing reference select codes
`define TIMREF_LOOP 2'h0
`define TIMREF_SLAVE 2'h1
// frame timing counts, in nibbles or reference clock periods
`define NIB_PER_FRAME 11'd1176
`define NIB_LAST 11'd1175
`define NIB_GAP 3'd4
`define NIB_GAP_LONG 3'd5
`define LONG_GAPS 4'd14
`define LONG_GAP_SPACING 11'd84
`define SAMPLE_EDGE 3'd3
`endif
